// ===== rtl/interrupt_task_dispatcher.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "irq_dispatch_defs.svh"
//////////////////////////////////////////////////////////////////////////////
module interrupt_task_dispatcher (
    input wire logic clk, // System clock, 10 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic op_start, // Start of operation pulse
    input wire irq_dispatch_pkg::reg_req_t bus, // Register port request
    output logic [15:0] rdata, // Register read data, one cycle after read
    input wire logic [`IO_COUNT-1:0] io_irq, // I/O interrupt pulses, tasks 100 to 131
    input wire logic [`SCHED_COUNT-1:0] sched_irq, // Scheduled interrupt pulses, tasks 2 and 3
    input wire irq_dispatch_pkg::ext_req_t ext_req, // External interrupt request
    input wire logic power_off_req, // Power-off detected pulse
    input wire logic task_done, // Engine finished the running task
    input wire logic legacy_refresh, // Legacy unit or remote refresh in progress
    input wire irq_dispatch_pkg::conflict_t conflict, // Refresh conflict report
    input wire logic prog_error_stop, // Program error stopped execution
    input wire logic [4:0] cyclic_task, // Cyclic task in effect
    output logic task_start, // Start pulse to the engine
    output logic [7:0] task_number, // Task to run or running
    output logic task_abort, // Abort pulse for the running task
    output logic unit_cmd_skip, // Conflicting unit command is skipped
    output logic irq_task_error_flag, // Interrupt task error flag
    output logic special_unit_error_flag, // Special unit error flag
    output logic special_refresh_stop // Special unit refresh stopped
);
    import irq_dispatch_pkg::*;

    disp_state_t s_reg;
    disp_state_t s_next;

    logic io_found;
    logic ext_found;
    logic sched_found;
    logic [7:0] io_idx;
    logic [7:0] ext_idx;
    logic [7:0] sched_idx;
    logic [15:0] elapsed;

    //////////////////////////////////////////////////////////////////////////
    // True when the given task is the one currently executing.
    function automatic logic is_running(input disp_state_t st, input logic [7:0] t);
        is_running = (st.mode != MODE_IDLE) && (st.mode != MODE_HALT) && (st.run_task == t);
    endfunction : is_running

    // True when a task number falls in the I/O range.
    function automatic logic in_io_range(input logic [7:0] t);
        in_io_range = (t >= `TASK_IO_BASE) && (t <= `TASK_IO_LAST);
    endfunction : in_io_range

    //////////////////////////////////////////////////////////////////////////
    pend_pick #(.N(`IO_COUNT)) u_pick_io (
        .pend(s_reg.io_pend),
        .found(io_found),
        .idx(io_idx)
    );

    pend_pick #(.N(`EXT_COUNT)) u_pick_ext (
        .pend(s_reg.ext_pend),
        .found(ext_found),
        .idx(ext_idx)
    );

    pend_pick #(.N(`SCHED_COUNT)) u_pick_sched (
        .pend(s_reg.sched_pend),
        .found(sched_found),
        .idx(sched_idx)
    );

    task_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(s_reg.start_pulse),
        .run((s_reg.mode == MODE_RUN) || (s_reg.mode == MODE_POWER)),
        .elapsed(elapsed)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic pwr_en;
        logic det_en;
        logic pwr_req;
        logic busy;
        logic [7:0] io_t;
        pwr_en = s_reg.setup[`SETUP_PWR_EN_BIT];
        det_en = !s_reg.setup[`SETUP_DET_DIS_BIT];
        busy = (s_reg.mode == MODE_RUN) || (s_reg.mode == MODE_POWER);
        pwr_req = power_off_req && pwr_en;
        io_t = 8'h00;

        s_next = s_reg;
        s_next.start_pulse = 1'b0;
        s_next.abort_pulse = 1'b0;
        s_next.skip_pulse = 1'b0;
        s_next.rdata = `WORD_ZERO;

        // Register reads answer in the next cycle; unmapped indices read zero.
        if (bus.rd) begin
            case (bus.addr)
                `REG_MAX_TIME: s_next.rdata = s_reg.max_time;
                `REG_MAX_TASK: s_next.rdata = s_reg.max_task;
                `REG_ERR_INFO: s_next.rdata = s_reg.err_info;
                `REG_STOPPED: s_next.rdata = s_reg.stopped;
                `REG_SETUP: s_next.rdata = s_reg.setup;
                `REG_STATUS: s_next.rdata = {11'h000, s_reg.refresh_stop, s_reg.su_err, s_reg.irq_err,
                                             s_reg.mode};
                default: s_next.rdata = `WORD_ZERO;
            endcase
        end

        if (bus.wr && (bus.addr == `REG_SETUP)) begin
            s_next.setup = bus.wdata;
        end

        // The clear is applied first so that a request arriving in the same cycle survives.
        if (bus.wr && (bus.addr == `REG_CLR_IO)) begin
            s_next.io_pend[bus.wdata[4:0]] = 1'b0;
        end

        for (int i = 0; i < `IO_COUNT; i++) begin
            io_t = `TASK_IO_BASE + 8'(i);
            if (io_irq[i] && !is_running(s_reg, io_t)) begin
                s_next.io_pend[i] = 1'b1;
            end
        end

        for (int i = 0; i < `SCHED_COUNT; i++) begin
            if (sched_irq[i] && !is_running(s_reg, `TASK_SCHED0 + 8'(i))) begin
                s_next.sched_pend[i] = 1'b1;
            end
        end

        // External numbers naming a scheduled or I/O task share that task's pending bit; task 1 with power-off enabled acts as a power-off request.
        if (ext_req.valid && !is_running(s_reg, ext_req.task_num)) begin
            if ((ext_req.task_num == `TASK_POWER) && pwr_en) begin
                pwr_req = 1'b1;
            end else if ((ext_req.task_num == `TASK_SCHED0) || (ext_req.task_num == `TASK_SCHED1)) begin
                s_next.sched_pend[ext_req.task_num[0]] = 1'b1;
            end else if (in_io_range(ext_req.task_num)) begin
                io_t = ext_req.task_num - `TASK_IO_BASE;
                s_next.io_pend[io_t[4:0]] = 1'b1;
            end else begin
                s_next.ext_pend[ext_req.task_num] = 1'b1;
            end
        end

        case (s_reg.mode)
            MODE_IDLE: begin
                if (pwr_req) begin
                    s_next.start_pulse = 1'b1;
                    s_next.run_task = `TASK_POWER;
                    s_next.mode = MODE_POWER;
                    s_next.io_pend = '0;
                    s_next.ext_pend = '0;
                    s_next.sched_pend = '0;
                end else if (io_found) begin
                    s_next.io_pend[io_idx[4:0]] = 1'b0;
                    s_next.run_task = `TASK_IO_BASE + io_idx;
                    s_next.start_pulse = 1'b1;
                    s_next.mode = MODE_RUN;
                end else if (ext_found) begin
                    s_next.ext_pend[ext_idx] = 1'b0;
                    s_next.run_task = ext_idx;
                    s_next.start_pulse = 1'b1;
                    s_next.mode = MODE_RUN;
                end else if (sched_found) begin
                    s_next.sched_pend[sched_idx[0]] = 1'b0;
                    s_next.run_task = `TASK_SCHED0 + sched_idx;
                    s_next.start_pulse = 1'b1;
                    s_next.mode = MODE_RUN;
                end
            end
            MODE_RUN: begin
                if (pwr_req) begin
                    // The aborted task is dropped and pending work is discarded.
                    s_next.abort_pulse = 1'b1;
                    s_next.start_pulse = 1'b1;
                    s_next.run_task = `TASK_POWER;
                    s_next.mode = MODE_POWER;
                    s_next.io_pend = '0;
                    s_next.ext_pend = '0;
                    s_next.sched_pend = '0;
                end else if (task_done) begin
                    s_next.mode = MODE_IDLE;
                end
            end
            MODE_POWER: begin
                if (task_done) begin
                    s_next.mode = MODE_HALT;
                end
            end
            MODE_HALT: begin
                s_next.mode = MODE_HALT;
            end
            default: begin
                s_next.mode = MODE_IDLE;
            end
        endcase

        // Longest execution time and its task are taken at each completion.
        if (busy && task_done) begin
            if (!s_reg.first_seen || (elapsed > s_reg.max_time)) begin
                s_next.max_time = elapsed;
                s_next.max_task = `IRQ_TAG | {8'h00, s_reg.run_task};
            end
            s_next.first_seen = 1'b1;
        end

        if (s_reg.start_pulse) begin
            s_next.over_seen = 1'b0;
        end else if (busy && legacy_refresh && !s_reg.over_seen && (elapsed > 16'(`OVERLONG_TICKS))) begin
            s_next.over_seen = 1'b1;
            s_next.su_err = 1'b1;
            s_next.refresh_stop = 1'b1;
            if (det_en) begin
                s_next.irq_err = 1'b1;
                s_next.err_info = {8'h00, s_reg.run_task};
            end
        end

        // A conflicting unit command is skipped; cyclic refresh is untouched.
        if (conflict.valid) begin
            s_next.skip_pulse = 1'b1;
            if (det_en) begin
                s_next.irq_err = 1'b1;
                s_next.err_info = `IRQ_TAG | {9'h000, conflict.unit};
            end
        end

        if (prog_error_stop) begin
            if (busy) begin
                s_next.stopped = `IRQ_TAG | {8'h00, s_reg.run_task};
            end else begin
                s_next.stopped = {11'h000, cyclic_task};
            end
        end

        // Start of operation wins over dispatch, pending bits, statistics and flags in its cycle; skip, err_info, stopped and setup still update.
        if (op_start) begin
            s_next.mode = MODE_IDLE;
            s_next.io_pend = '0;
            s_next.ext_pend = '0;
            s_next.sched_pend = '0;
            s_next.start_pulse = 1'b0;
            s_next.abort_pulse = 1'b0;
            s_next.max_time = `WORD_ZERO;
            s_next.max_task = `WORD_ZERO;
            s_next.first_seen = 1'b0;
            s_next.irq_err = 1'b0;
            s_next.su_err = 1'b0;
            s_next.refresh_stop = 1'b0;
            s_next.over_seen = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.setup <= `SETUP_RESET;
            s_reg.mode <= MODE_IDLE;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign task_start = s_reg.start_pulse;
    assign task_number = s_reg.run_task;
    assign task_abort = s_reg.abort_pulse;
    assign unit_cmd_skip = s_reg.skip_pulse;
    assign irq_task_error_flag = s_reg.irq_err;
    assign special_unit_error_flag = s_reg.su_err;
    assign special_refresh_stop = s_reg.refresh_stop;
endmodule : interrupt_task_dispatcher

// ===== rtl/irq_dispatch_defs.svh
`ifndef IRQ_DISPATCH_DEFS_SVH
`define IRQ_DISPATCH_DEFS_SVH

// Register indices on the plain register port.
`define REG_MAX_TIME 4'h0
`define REG_MAX_TASK 4'h1
`define REG_ERR_INFO 4'h2
`define REG_STOPPED 4'h3
`define REG_SETUP 4'h4
`define REG_CLR_IO 4'h5
`define REG_STATUS 4'h6

// Setup word fields and reset value.
`define SETUP_PWR_EN_BIT 15
`define SETUP_DET_DIS_BIT 14
`define SETUP_RESET 16'h0000

// Task numbers.
`define TASK_POWER 8'h01
`define TASK_SCHED0 8'h02
`define TASK_SCHED1 8'h03
`define TASK_IO_BASE 8'h64
`define TASK_IO_LAST 8'h83
`define IO_COUNT 32
`define SCHED_COUNT 2
`define EXT_COUNT 256

// Word encodings.
`define IRQ_TAG 16'h8000
`define ERR_KIND_BIT 15
`define WORD_ZERO 16'h0000

// Timing.
`define CLK_PERIOD_NS 100
`define TICK_NS 100000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_DIV_W 10
`define OVERLONG_MS 10
`define OVERLONG_TICKS (`OVERLONG_MS * 1000000 / `TICK_NS)

`endif

// ===== rtl/irq_dispatch_pkg.sv
package irq_dispatch_pkg;
`include "irq_dispatch_defs.svh"

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_RUN = 2'b01,
        MODE_POWER = 2'b10,
        MODE_HALT = 2'b11
    } mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] task_num;
    } ext_req_t;

    typedef struct packed {
        logic valid;
        logic [6:0] unit;
    } conflict_t;

    typedef struct packed {
        logic [`TICK_DIV_W-1:0] div;
        logic [15:0] ticks;
    } timer_state_t;

    typedef struct packed {
        mode_t mode;
        logic [`IO_COUNT-1:0] io_pend;
        logic [`EXT_COUNT-1:0] ext_pend;
        logic [`SCHED_COUNT-1:0] sched_pend;
        logic [7:0] run_task;
        logic start_pulse;
        logic abort_pulse;
        logic skip_pulse;
        logic [15:0] max_time;
        logic [15:0] max_task;
        logic first_seen;
        logic [15:0] err_info;
        logic [15:0] stopped;
        logic [15:0] setup;
        logic irq_err;
        logic su_err;
        logic refresh_stop;
        logic over_seen;
        logic [15:0] rdata;
    } disp_state_t;

endpackage : irq_dispatch_pkg

// ===== rtl/pend_pick.sv
`timescale 1ns/100ps
module pend_pick #(
    parameter int N = 32
) (
    input wire logic [N-1:0] pend, // Pending bits of one request kind
    output logic found, // Some bit is set
    output logic [7:0] idx // Lowest set index
);
    always_comb begin
        found = 1'b0;
        idx = 8'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                found = 1'b1;
                idx = 8'(i);
            end
        end
    end
endmodule : pend_pick

// ===== rtl/task_timer.sv
`timescale 1ns/100ps
`include "irq_dispatch_defs.svh"
module task_timer (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic start, // Restart the measurement
    input wire logic run, // A task is executing
    output logic [15:0] elapsed // Execution time in 0.1 ms units
);
    import irq_dispatch_pkg::*;

    timer_state_t s_reg;
    timer_state_t s_next;

    // Counts whole 0.1 ms ticks of execution and saturates at full scale.
    always_comb begin
        s_next = s_reg;
        if (start) begin
            s_next.div = '0;
            s_next.ticks = `WORD_ZERO;
        end else if (run) begin
            if (s_reg.div == `TICK_DIV_W'(`TICK_CYCLES - 1)) begin
                s_next.div = '0;
                if (s_reg.ticks != 16'hFFFF) begin
                    s_next.ticks = s_reg.ticks + 16'h0001;
                end
            end else begin
                s_next.div = s_reg.div + `TICK_DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign elapsed = s_reg.ticks;
endmodule : task_timer

// ===== verification/dispatch_assertions.sv
`timescale 1ns/100ps
module dispatch_checker (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic op_start, // Soft clear
    input wire logic task_done, // Engine finished
    input wire logic legacy_refresh, // Legacy refresh running
    input wire irq_dispatch_pkg::conflict_t conflict, // Conflict report
    input wire logic task_start, // Start pulse
    input wire logic [7:0] task_number, // Dispatched task
    input wire logic task_abort, // Abort pulse
    input wire logic unit_cmd_skip, // Skip pulse
    input wire logic irq_task_error_flag, // Task error flag
    input wire logic special_unit_error_flag, // Unit error flag
    input wire logic special_refresh_stop // Refresh stopped
);
    import irq_dispatch_pkg::*;
    logic busy_q;
    // Tracks whether the engine holds a task, from the outside view.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= task_start | (busy_q & ~task_done & ~op_start);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_start_single: assert property (task_start |=> !task_start)
        else $error("start pulse longer than one cycle");
    chk_no_nesting: assert property (task_start && !task_abort |-> !busy_q)
        else $error("task started while another runs");
    chk_abort_power: assert property (task_abort |-> task_start && task_number == 8'h01)
        else $error("abort without power-off task start");
    chk_skip_follow: assert property (conflict.valid |=> unit_cmd_skip)
        else $error("conflict not skipped");
    chk_skip_cause: assert property (unit_cmd_skip |-> $past(conflict.valid))
        else $error("skip without conflict");
    chk_err_sticky: assert property (irq_task_error_flag && !op_start |=> irq_task_error_flag)
        else $error("task error flag dropped");
    chk_stop_with_err: assert property ($rose(special_unit_error_flag) |-> $rose(special_refresh_stop))
        else $error("unit refresh not stopped with error");
    chk_overlong_cause: assert property ($rose(special_unit_error_flag) |-> $past(legacy_refresh) && $past(busy_q))
        else $error("unit error without long task in refresh");
    cover property (task_start && task_abort);
    cover property (unit_cmd_skip && irq_task_error_flag);
    cover property ($rose(special_unit_error_flag));
endmodule : dispatch_checker
bind interrupt_task_dispatcher dispatch_checker dispatch_checker_i (.clk(clk), .rst_n(rst_n), .op_start(op_start),
    .task_done(task_done), .legacy_refresh(legacy_refresh), .conflict(conflict), .task_start(task_start),
    .task_number(task_number), .task_abort(task_abort), .unit_cmd_skip(unit_cmd_skip),
    .irq_task_error_flag(irq_task_error_flag), .special_unit_error_flag(special_unit_error_flag),
    .special_refresh_stop(special_refresh_stop));

// ===== verification/interrupt_task_dispatcher_tb.sv
`timescale 1ns/100ps
module interrupt_task_dispatcher_tb;
    import irq_dispatch_pkg::*;
    logic clk, rst_n, ce, op_start, power_off_req, task_done, legacy_refresh, prog_error_stop;
    logic task_start, task_abort, unit_cmd_skip, irq_task_error_flag, special_unit_error_flag, special_refresh_stop;
    logic [4:0] cyclic_task;
    logic [1:0] sched_irq;
    logic [7:0] task_number;
    logic [15:0] rdata;
    logic [19:0] run_len;
    logic [31:0] io_irq;
    reg_req_t bus;
    ext_req_t ext_req;
    conflict_t conflict;
    int n_fail = 0;
    int cmp_count = 0;
    interrupt_task_dispatcher interrupt_task_dispatcher_i (.clk(clk), .rst_n(rst_n), .ce(ce), .op_start(op_start),
        .bus(bus), .rdata(rdata), .io_irq(io_irq), .sched_irq(sched_irq), .ext_req(ext_req),
        .power_off_req(power_off_req), .task_done(task_done), .legacy_refresh(legacy_refresh), .conflict(conflict),
        .prog_error_stop(prog_error_stop), .cyclic_task(cyclic_task), .task_start(task_start),
        .task_number(task_number), .task_abort(task_abort), .unit_cmd_skip(unit_cmd_skip),
        .irq_task_error_flag(irq_task_error_flag), .special_unit_error_flag(special_unit_error_flag),
        .special_refresh_stop(special_refresh_stop));
    task_engine_model task_engine_model_i (.clk(clk), .rst_n(rst_n), .task_start(task_start), .run_len(run_len),
        .task_done(task_done));
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : reg_wr
    task automatic reg_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        chk16(nm, e, rdata);
        @(posedge clk);
    endtask : reg_chk
    task automatic ext(input logic [7:0] t);
        ext_req <= '{1'b1, t};
        @(posedge clk);
        ext_req <= '0;
    endtask : ext
    task automatic pulse_clear();
        op_start <= 1'b1;
        @(posedge clk);
        op_start <= 1'b0;
        @(posedge clk);
    endtask : pulse_clear
    task automatic wait_start(input logic [7:0] e);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(posedge clk);
            if (task_start === 1'b1) break;
        end
        chk16("task_number", {8'h00, e}, (task_start === 1'b1) ? {8'h00, task_number} : 16'hFFFF);
    endtask : wait_start
    task automatic no_start(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if (task_start !== 1'b0) seen = 1'b1;
        end
        chk16("no_dispatch", 16'h0000, {15'h0000, seen});
    endtask : no_start
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200000; i++) begin
            @(posedge clk);
            if (task_done === 1'b1) break;
        end
        repeat (3) @(posedge clk);
    endtask : wait_idle
    task automatic run_io0();
        io_irq <= 32'h00000001;
        @(posedge clk);
        io_irq <= 32'h00000000;
        wait_start(8'h64);
    endtask : run_io0
    task automatic t_reset();
        reg_wr(4'h0, 16'hFFFF);
        reg_chk("max_time", 4'h0, 16'h0000);
        reg_chk("max_task", 4'h1, 16'h0000);
        reg_chk("setup", 4'h4, 16'h0000);
        reg_chk("unmapped", 4'hF, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_priority();
        logic [7:0] order [6] = '{8'h65, 8'h66, 8'h69, 8'h07, 8'h02, 8'h03};
        run_len <= 20'h0001E;
        run_io0();
        io_irq <= 32'h00000024;
        ext_req <= '{1'b1, 8'h65};
        sched_irq <= 2'b11;
        @(posedge clk);
        io_irq <= 32'h00000007;
        ext_req <= '{1'b1, 8'h07};
        sched_irq <= 2'b00;
        @(posedge clk);
        io_irq <= 32'h00000000;
        ext_req <= '0;
        foreach (order[k]) wait_start(order[k]);
        no_start(80);
        $display("test priority done");
    endtask : t_priority
    task automatic t_clear();
        run_io0();
        io_irq <= 32'h00000010;
        sched_irq <= 2'b01;
        ext_req <= '{1'b1, 8'h09};
        @(posedge clk);
        io_irq <= 32'h00000000;
        sched_irq <= 2'b00;
        ext_req <= '0;
        reg_wr(4'h5, 16'h0004);
        wait_start(8'h09);
        wait_start(8'h02);
        no_start(80);
        $display("test clear done");
    endtask : t_clear
    task automatic t_stats();
        pulse_clear();
        reg_chk("max_time", 4'h0, 16'h0000);
        run_len <= 20'h009C4;
        ext(8'hC8);
        wait_start(8'hC8);
        wait_idle();
        run_len <= 20'h00064;
        ext(8'h05);
        wait_start(8'h05);
        wait_idle();
        reg_chk("max_time", 4'h0, 16'h0002);
        reg_chk("max_task", 4'h1, 16'h80C8);
        $display("test stats done");
    endtask : t_stats
    task automatic t_conflict();
        reg_wr(4'h4, 16'h4000);
        conflict <= '{1'b1, 7'h03};
        @(posedge clk);
        conflict <= '0;
        @(negedge clk);
        chk16("skip", 16'h0001, {15'h0000, unit_cmd_skip});
        chk16("err_flag", 16'h0000, {15'h0000, irq_task_error_flag});
        @(posedge clk);
        reg_wr(4'h4, 16'h0000);
        conflict <= '{1'b1, 7'h5F};
        @(posedge clk);
        conflict <= '0;
        @(negedge clk);
        chk16("skip", 16'h0001, {15'h0000, unit_cmd_skip});
        chk16("err_flag", 16'h0001, {15'h0000, irq_task_error_flag});
        @(posedge clk);
        reg_chk("err_info", 4'h2, 16'h805F);
        $display("test conflict done");
    endtask : t_conflict
    task automatic t_stop();
        cyclic_task <= 5'h1F;
        prog_error_stop <= 1'b1;
        @(posedge clk);
        prog_error_stop <= 1'b0;
        reg_chk("stopped", 4'h3, 16'h001F);
        run_len <= 20'h00028;
        ext(8'hFF);
        wait_start(8'hFF);
        prog_error_stop <= 1'b1;
        @(posedge clk);
        prog_error_stop <= 1'b0;
        reg_chk("stopped", 4'h3, 16'h80FF);
        wait_idle();
        $display("test stop done");
    endtask : t_stop
    task automatic t_overlong();
        pulse_clear();
        legacy_refresh <= 1'b1;
        run_len <= 20'h19064;
        ext(8'h33);
        wait_start(8'h33);
        wait_idle();
        legacy_refresh <= 1'b0;
        chk16("flags", 16'h0007, {13'h0000, special_unit_error_flag, special_refresh_stop, irq_task_error_flag});
        reg_chk("err_info", 4'h2, 16'h0033);
        $display("test overlong done");
    endtask : t_overlong
    task automatic t_power();
        pulse_clear();
        run_len <= 20'h00028;
        run_io0();
        power_off_req <= 1'b1;
        @(posedge clk);
        power_off_req <= 1'b0;
        no_start(10);
        wait_idle();
        reg_wr(4'h4, 16'h8000);
        run_io0();
        io_irq <= 32'h00000008;
        @(posedge clk);
        io_irq <= 32'h00000000;
        power_off_req <= 1'b1;
        @(posedge clk);
        power_off_req <= 1'b0;
        wait_start(8'h01);
        chk16("abort", 16'h0001, {15'h0000, task_abort});
        no_start(80);
        pulse_clear();
        $display("test power done");
    endtask : t_power
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #20000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        op_start = 1'b0;
        bus = '0;
        io_irq = '0;
        sched_irq = '0;
        ext_req = '0;
        power_off_req = 1'b0;
        legacy_refresh = 1'b0;
        conflict = '0;
        prog_error_stop = 1'b0;
        cyclic_task = '0;
        run_len = 20'h0001E;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_priority();
        t_clear();
        t_stats();
        t_conflict();
        t_stop();
        t_overlong();
        t_power();
        print_verdict();
    end
endmodule : interrupt_task_dispatcher_tb

// ===== verification/task_engine_model.sv
`timescale 1ns/100ps
module task_engine_model (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic task_start, // Start from dispatcher
    input wire logic [19:0] run_len, // Cycles a task runs
    output logic task_done // Finished pulse
);
    typedef struct packed {
        logic busy;
        logic [19:0] cnt;
        logic done;
    } eng_state_t;
    eng_state_t state_reg;
    eng_state_t state_next;
    // A new start, the power-off one too, restarts the count.
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        if (task_start) begin
            state_next.busy = 1'b1;
            state_next.cnt = run_len;
        end else if (state_reg.busy) begin
            state_next.cnt = state_reg.cnt - 20'h00001;
            if (state_reg.cnt == 20'h00001) begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign task_done = state_reg.done;
endmodule : task_engine_model
